// *** core/sram_port_defines.svh ***
// Constants of the serial RAM slave port: reset values, field positions and counts
`ifndef SRAM_PORT_DEFINES_SVH
`define SRAM_PORT_DEFINES_SVH

`define BYTE_BITS 4'h8
`define ACK_SLOT_DONE 4'h1
`define CNT_RESET 4'h0
`define WORD_ADDR_RESET 8'h00
`define BYTE_RESET 8'h00
`define PIN_SYNC_RESET 3'h7
`define SELECT_SYNC_RESET 6'h00
`define DIR_BIT 0
`define DEV_ADDR_MSB 7
`define DEV_ADDR_LSB 1
`define TX_MSB 7
`define RAM_WORDS 256
`define RAM_ADDR_BITS 8

`endif

// *** core/sram_port_pkg.sv ***
// Types shared by the serial RAM slave port and its link-side sampler
package sram_port_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_RX_ACK,
    ST_TX,
    ST_TX_ACK
  } port_state_e;

  typedef struct packed {
    logic [7:0] shift;
  } link_sample_s;

endpackage

// *** core/scl_bit_sampler.sv ***
// Link-side sampler: shifts the data line in on every rising serial clock edge
`timescale 1ns/1ps
`include "sram_port_defines.svh"

module scl_bit_sampler (
  input wire logic scl_clk_i,                     // Serial clock, link domain
  input wire logic sda_i,                         // Data line level
  output sram_port_pkg::link_sample_s sample_o    // Last eight sampled bits
);

  logic [7:0] shift_q;
  logic [7:0] shift_d;

  // Held for a whole clock period, so the core may read it after seeing the edge
  always_comb begin
    shift_d = {shift_q[6:0], sda_i};
  end

  always_ff @(posedge scl_clk_i) begin
    shift_q <= shift_d;
  end

  assign sample_o.shift = shift_q;

endmodule

// *** core/i2c_serial_ram_slave_port.sv ***
// Two-wire serial slave port with a 256 x 8 word store
`timescale 1ns/1ps
`include "sram_port_defines.svh"

module i2c_serial_ram_slave_port #(
  parameter logic [3:0] FIXED_GROUP = 4'h5,  // Fixed upper address bits, value arbitrary
  parameter int DEPTH = `RAM_WORDS           // Number of stored words
) (
  input wire logic core_clk_i,               // Core clock, 200 MHz
  input wire logic rst_i,                    // Synchronous reset, active high
  input wire logic scl_clk_i,                // Serial clock line from master
  input wire logic sda_i,                    // Serial data line level
  input wire logic addr_select_bit_low_i,    // Address select pin, bit 1 of address byte
  input wire logic addr_select_bit_mid_i,    // Address select pin, bit 2 of address byte
  input wire logic addr_select_bit_high_i,   // Address select pin, bit 3 of address byte
  input wire logic power_save_req_i,         // Power-saving request, high active
  output logic sda_o,                        // Data line drive value, always low
  output logic sda_oe_o,                     // High while pulling data line low
  output logic power_save_o                  // Port held in power saving
);

  sram_port_pkg::link_sample_s link_sample;
  sram_port_pkg::port_state_e state_q, state_d;

  logic [2:0] scl_sync_q, scl_sync_d;
  logic [2:0] sda_sync_q, sda_sync_d;
  logic [1:0] ps_sync_q, ps_sync_d;
  logic [5:0] sel_sync_q, sel_sync_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] ptr_q, ptr_d;
  logic [7:0] tx_q, tx_d;
  logic addr_phase_q, addr_phase_d;
  logic waddr_phase_q, waddr_phase_d;
  logic read_q, read_d;
  logic sda_oe_q, sda_oe_d;
  logic sda_out_q;
  logic ps_q, ps_d;
  logic scl_rise, scl_fall, start_evt, stop_evt;
  logic [6:0] own_addr;
  logic [7:0] rx_byte;
  logic [7:0] rd_word;
  logic ram_we;
  logic [7:0] ram_q [DEPTH];

  scl_bit_sampler u_sampler (
    .scl_clk_i (scl_clk_i),
    .sda_i     (sda_i),
    .sample_o  (link_sample)
  );

  // Pin synchronisers; stage 0 feeds only stage 1
  always_comb begin
    scl_sync_d = {scl_sync_q[1:0], scl_clk_i};
    sda_sync_d = {sda_sync_q[1:0], sda_i};
    ps_sync_d = {ps_sync_q[0], power_save_req_i};
    sel_sync_d = {sel_sync_q[2:0], addr_select_bit_high_i, addr_select_bit_mid_i,
                  addr_select_bit_low_i};
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      scl_sync_q <= `PIN_SYNC_RESET;
      sda_sync_q <= `PIN_SYNC_RESET;
      ps_sync_q <= 2'h0;
      sel_sync_q <= `SELECT_SYNC_RESET;
    end else begin
      scl_sync_q <= scl_sync_d;
      sda_sync_q <= sda_sync_d;
      ps_sync_q <= ps_sync_d;
      sel_sync_q <= sel_sync_d;
    end
  end

  assign scl_rise = scl_sync_q[1] & ~scl_sync_q[2];
  assign scl_fall = ~scl_sync_q[1] & scl_sync_q[2];
  // data edges while clock high are control events
  assign start_evt = scl_sync_q[1] & scl_sync_q[2] & ~sda_sync_q[1] & sda_sync_q[2];
  assign stop_evt = scl_sync_q[1] & scl_sync_q[2] & sda_sync_q[1] & ~sda_sync_q[2];

  // fixed group above the three select pins
  assign own_addr = {FIXED_GROUP, sel_sync_q[5:3]};
  assign rx_byte = link_sample.shift;
  // word store indexed by the word address
  assign rd_word = ram_q[ptr_q];

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    ptr_d = ptr_q;
    tx_d = tx_q;
    addr_phase_d = addr_phase_q;
    waddr_phase_d = waddr_phase_q;
    read_d = read_q;
    sda_oe_d = sda_oe_q;
    ram_we = 1'b0;
    // power-saving request is a plain input, normally low
    ps_d = ps_sync_q[1];
    // power saving returns the bus logic to idle
    if (ps_sync_q[1]) begin
      state_d = sram_port_pkg::ST_IDLE;
      sda_oe_d = 1'b0;
      cnt_d = `CNT_RESET;
    end else if (start_evt) begin
      // start restarts bit and byte framing
      state_d = sram_port_pkg::ST_RX;
      cnt_d = `CNT_RESET;
      addr_phase_d = 1'b1;
      waddr_phase_d = 1'b0;
      read_d = 1'b0;
      sda_oe_d = 1'b0;
    end else if (stop_evt) begin
      state_d = sram_port_pkg::ST_IDLE;
      sda_oe_d = 1'b0;
      cnt_d = `CNT_RESET;
    end else begin
      unique case (state_q)
        sram_port_pkg::ST_IDLE: begin
          sda_oe_d = 1'b0;
        end
        sram_port_pkg::ST_RX: begin
          // eight data bits, then the acknowledge slot
          if (scl_rise && cnt_q != `BYTE_BITS) begin
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == `BYTE_BITS) begin
            cnt_d = `CNT_RESET;
            if (addr_phase_q) begin
              addr_phase_d = 1'b0;
              // only a matching address byte is served
              if (rx_byte[`DEV_ADDR_MSB:`DEV_ADDR_LSB] == own_addr) begin
                read_d = rx_byte[`DIR_BIT];
                waddr_phase_d = ~rx_byte[`DIR_BIT];
                sda_oe_d = 1'b1;
                state_d = sram_port_pkg::ST_RX_ACK;
              end else begin
                state_d = sram_port_pkg::ST_IDLE;
              end
            end else if (waddr_phase_q) begin
              // first written byte loads the word address
              ptr_d = rx_byte;
              waddr_phase_d = 1'b0;
              sda_oe_d = 1'b1;
              state_d = sram_port_pkg::ST_RX_ACK;
            end else begin
              ram_we = 1'b1;
              ptr_d = ptr_q + 8'h01;
              sda_oe_d = 1'b1;
              state_d = sram_port_pkg::ST_RX_ACK;
            end
          end
        end
        sram_port_pkg::ST_RX_ACK: begin
          // held low until the falling edge after the slot
          if (scl_rise) begin
            cnt_d = `ACK_SLOT_DONE;
          end else if (scl_fall && cnt_q == `ACK_SLOT_DONE) begin
            cnt_d = `CNT_RESET;
            if (read_q) begin
              tx_d = rd_word;
              ptr_d = ptr_q + 8'h01;
              // a one bit is sent by releasing the line
              sda_oe_d = ~rd_word[`TX_MSB];
              state_d = sram_port_pkg::ST_TX;
            end else begin
              sda_oe_d = 1'b0;
              state_d = sram_port_pkg::ST_RX;
            end
          end
        end
        sram_port_pkg::ST_TX: begin
          if (scl_rise) begin
            cnt_d = cnt_q + 4'h1;
            tx_d = {tx_q[6:0], 1'b0};
          end else if (scl_fall) begin
            if (cnt_q == `BYTE_BITS) begin
              // transmitter releases during the acknowledge slot
              cnt_d = `CNT_RESET;
              sda_oe_d = 1'b0;
              state_d = sram_port_pkg::ST_TX_ACK;
            end else begin
              sda_oe_d = ~tx_q[`TX_MSB];
            end
          end
        end
        sram_port_pkg::ST_TX_ACK: begin
          if (scl_rise) begin
            // low slot means master wants more
            if (!rx_byte[0]) begin
              cnt_d = `ACK_SLOT_DONE;
            end else begin
              state_d = sram_port_pkg::ST_IDLE;
              sda_oe_d = 1'b0;
            end
          end else if (scl_fall && cnt_q == `ACK_SLOT_DONE) begin
            cnt_d = `CNT_RESET;
            tx_d = rd_word;
            ptr_d = ptr_q + 8'h01;
            sda_oe_d = ~rd_word[`TX_MSB];
            state_d = sram_port_pkg::ST_TX;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= sram_port_pkg::ST_IDLE;
      cnt_q <= `CNT_RESET;
      ptr_q <= `WORD_ADDR_RESET;
      tx_q <= `BYTE_RESET;
      addr_phase_q <= 1'b0;
      waddr_phase_q <= 1'b0;
      read_q <= 1'b0;
      sda_oe_q <= 1'b0;
      sda_out_q <= 1'b0;
      ps_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      ptr_q <= ptr_d;
      tx_q <= tx_d;
      addr_phase_q <= addr_phase_d;
      waddr_phase_q <= waddr_phase_d;
      read_q <= read_d;
      sda_oe_q <= sda_oe_d;
      sda_out_q <= 1'b0;
      ps_q <= ps_d;
    end
  end

  // Store has no reset so its contents survive power saving
  always_ff @(posedge core_clk_i) begin
    if (ram_we) begin
      ram_q[ptr_q] <= rx_byte;
    end
  end

  assign sda_o = sda_out_q;
  assign sda_oe_o = sda_oe_q;
  assign power_save_o = ps_q;

  a_drive_low_only: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !sda_o) else $error("data line driven high");

  a_idle_released: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_q == sram_port_pkg::ST_IDLE |-> !sda_oe_o) else $error("idle port pulls line");

  a_start_frames: assert property (@(posedge core_clk_i) disable iff (rst_i)
    start_evt && !ps_sync_q[1] |=> state_q == sram_port_pkg::ST_RX && cnt_q == 4'h0
    && addr_phase_q && !sda_oe_o) else $error("start did not restart framing");

  a_stop_idles: assert property (@(posedge core_clk_i) disable iff (rst_i)
    stop_evt |=> state_q == sram_port_pkg::ST_IDLE && !sda_oe_o)
    else $error("stop did not return to idle");

  a_bit_count: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_q == sram_port_pkg::ST_RX && scl_rise && cnt_q < 4'h8 && !start_evt
    && !stop_evt && !ps_sync_q[1] |=> cnt_q == $past(cnt_q) + 4'h1)
    else $error("bit count did not advance");

  a_write_acked: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ram_we |=> sda_oe_o && state_q == sram_port_pkg::ST_RX_ACK)
    else $error("written byte not acknowledged");

  a_ack_held: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_q == sram_port_pkg::ST_RX_ACK && scl_rise |-> sda_oe_o)
    else $error("acknowledge not low at clock rise");

  a_nack_release: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_q == sram_port_pkg::ST_TX_ACK && scl_rise && rx_byte[0] && !start_evt
    && !stop_evt && !ps_sync_q[1] |=> state_q == sram_port_pkg::ST_IDLE
    ##1 !sda_oe_o [*2]) else $error("port kept sending after missing acknowledge");

  a_ptr_advance: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ram_we |=> ptr_q == $past(ptr_q) + 8'h01) else $error("word address not advanced");

  a_power_save: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ps_sync_q[1] |=> state_q == sram_port_pkg::ST_IDLE && !sda_oe_o && power_save_o)
    else $error("power saving did not reset bus logic");

  a_addr_mismatch: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_q == sram_port_pkg::ST_RX && addr_phase_q && scl_fall && cnt_q == 4'h8
    && !start_evt && !stop_evt && !ps_sync_q[1]
    && rx_byte[7:1] != own_addr |=> state_q == sram_port_pkg::ST_IDLE && !sda_oe_o)
    else $error("foreign address acknowledged");

endmodule

// *** sim/bus_master_model.sv ***
// Behavioural two-wire bus master that frames bytes for the serial RAM port
`timescale 1ns/1ps
module bus_master_model (
  input wire logic sda_i,   // Resolved data line level
  output logic scl_o,       // Serial clock, high while idle
  output logic sda_pull_o   // High while pulling the data line low
);
  // Low phase is two steps so data moves 10 ns clear of both clock edges; 30 ns per bit
  localparam int PH = 10;
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  // one bit per pulse
  // A line that moves while the clock is high comes back as unknown
  task automatic bit_cycle(input logic b, output logic seen);
    // On an idle bus lower the clock first, so a leading zero is not a start
    if (scl_o === 1'b1) begin
      #PH;
      scl_o = 1'b0;
    end
    #PH;
    sda_pull_o = ~b;
    #PH;
    scl_o = 1'b1;
    seen = sda_i;
    #PH;
    if (sda_i !== seen) seen = 1'bx;
    scl_o = 1'b0;
  endtask
  task automatic start();
    if (scl_o === 1'b0) begin
      #PH;
      sda_pull_o = 1'b0;
      #PH;
      scl_o = 1'b1;
    end
    #PH;
    sda_pull_o = 1'b1;
    #PH;
    scl_o = 1'b0;
  endtask
  // stop, then both lines rest high
  task automatic stop();
    #PH;
    sda_pull_o = 1'b1;
    #PH;
    scl_o = 1'b1;
    #PH;
    sda_pull_o = 1'b0;
    #(4 * PH);
  endtask
  // eight bits, then a released slot
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(d[i], s);
    end
    bit_cycle(1'b1, s);
    ack = ~s;
  endtask
  // acknowledge all but the last byte wanted
  task automatic recv(input logic give_ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, s);
      d[i] = s;
    end
    bit_cycle(~give_ack, s);
  endtask
endmodule

// *** sim/i2c_serial_ram_slave_port_bench.sv ***
// Self-checking bench for the serial RAM slave port driven by a bus master model
`timescale 1ns/1ps
module i2c_serial_ram_slave_port_bench;
  localparam logic [3:0] GROUP = 4'h5; // Arbitrary fixed group for this run
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] sel = 3'h0;
  logic psave = 1'b0;
  logic scl, mst_pull, sda_line, sda_o, sda_oe, psave_o;
  int miscompares = 0;
  int total_checks = 0;
  always #2.5 core_clk = ~core_clk;
  // Pull-up wins unless someone pulls low
  assign sda_line = ~((sda_oe & ~sda_o) | mst_pull);
  i2c_serial_ram_slave_port #(.FIXED_GROUP(GROUP)) i2c_serial_ram_slave_port_inst (
    .core_clk_i(core_clk),
    .rst_i(rst),
    .scl_clk_i(scl),
    .sda_i(sda_line),
    .addr_select_bit_low_i(sel[0]),
    .addr_select_bit_mid_i(sel[1]),
    .addr_select_bit_high_i(sel[2]),
    .power_save_req_i(psave),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe),
    .power_save_o(psave_o)
  );
  bus_master_model bus_master_model_inst (
    .sda_i(sda_line),
    .scl_o(scl),
    .sda_pull_o(mst_pull)
  );
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  function automatic logic [7:0] addr(input logic [2:0] s, input logic rw);
    return {GROUP, s, rw};
  endfunction
  // Pins pass two-flop synchronisers, so give them time to settle
  task automatic pins(input logic [2:0] s, input logic p);
    @(posedge core_clk);
    sel <= s;
    psave <= p;
    repeat (8) @(posedge core_clk);
    // Step off the core edge so link edges never meet a sampling edge
    #1;
  endtask
  always @(posedge core_clk) begin
    if (sda_oe === 1'b1)
      check({7'h00, sda_o}, 8'h00, "drive level");
  end
  task automatic t_reset_idle();
    #1;
    check({6'h00, sda_oe, psave_o}, 8'h00, "idle outputs");
    check({7'h00, sda_line}, 8'h01, "idle line");
  endtask
  task automatic t_select();
    logic a;
    for (int s = 0; s < 8; s++) begin
      pins(3'(s), 1'b0);
      bus_master_model_inst.start();
      bus_master_model_inst.send(addr(3'(s), 1'b0), a);
      check({7'h00, a}, 8'h01, "own address");
      bus_master_model_inst.stop();
      bus_master_model_inst.send(addr(3'(s), 1'b0), a);
      check({7'h00, a}, 8'h00, "byte after stop");
      bus_master_model_inst.start();
      bus_master_model_inst.send(addr(3'(s + 1), 1'b0), a);
      check({7'h00, a}, 8'h00, "other select");
      bus_master_model_inst.start();
      bus_master_model_inst.send({GROUP ^ 4'h8, 3'(s), 1'b0}, a);
      check({7'h00, a}, 8'h00, "other group");
      bus_master_model_inst.stop();
    end
  endtask
  task automatic t_write_read();
    logic a;
    logic [7:0] d;
    logic [7:0] wr [4] = '{8'hA5, 8'h3C, 8'h96, 8'h17};
    pins(3'h2, 1'b0);
    bus_master_model_inst.start();
    bus_master_model_inst.send(addr(3'h2, 1'b0), a);
    for (int i = 0; i < 3; i++) begin
      bus_master_model_inst.bit_cycle(1'b0, a);
    end
    bus_master_model_inst.start();
    bus_master_model_inst.send(addr(3'h2, 1'b0), a);
    check({7'h00, a}, 8'h01, "address after restart");
    bus_master_model_inst.send(8'hFE, a);
    check({7'h00, a}, 8'h01, "word address ack");
    foreach (wr[i]) begin
      bus_master_model_inst.send(wr[i], a);
      check({7'h00, a}, 8'h01, "data ack");
    end
    bus_master_model_inst.stop();
    bus_master_model_inst.start();
    bus_master_model_inst.send(addr(3'h2, 1'b0), a);
    bus_master_model_inst.send(8'hFE, a);
    bus_master_model_inst.start();
    bus_master_model_inst.send(addr(3'h2, 1'b1), a);
    check({7'h00, a}, 8'h01, "read address ack");
    for (int i = 0; i < 3; i++) begin
      bus_master_model_inst.recv(i < 2, d);
      check(d, wr[i], "read data");
    end
    // Next word starts with a zero bit, so a port that kept sending would pull low
    #30;
    check({7'h00, sda_oe}, 8'h00, "release after no ack");
    bus_master_model_inst.stop();
  endtask
  task automatic t_power();
    logic a;
    pins(3'h7, 1'b0);
    bus_master_model_inst.start();
    bus_master_model_inst.send(addr(3'h7, 1'b0), a);
    check({7'h00, a}, 8'h01, "address before sleep");
    pins(3'h7, 1'b1);
    check({7'h00, psave_o}, 8'h01, "power save flag");
    bus_master_model_inst.send(8'h00, a);
    check({7'h00, a}, 8'h00, "byte in sleep");
    bus_master_model_inst.stop();
    bus_master_model_inst.start();
    bus_master_model_inst.send(addr(3'h7, 1'b0), a);
    check({7'h00, a}, 8'h00, "address in sleep");
    bus_master_model_inst.stop();
    pins(3'h7, 1'b0);
    check({7'h00, psave_o}, 8'h00, "power save cleared");
    bus_master_model_inst.start();
    bus_master_model_inst.send(addr(3'h7, 1'b0), a);
    check({7'h00, a}, 8'h01, "address after wake");
    bus_master_model_inst.stop();
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    repeat (8) @(posedge core_clk);
    t_reset_idle();
    t_select();
    t_write_read();
    t_power();
    results();
  end
  initial begin
    #200000;
    miscompares++;
    results();
  end
endmodule
